// >>> logic/fpp_page_program.sv
// page program path with per-unit automatic ecc, serial link front end
// assumes spi mode 0 sampling on rising spi_sck; spi_sck stands between
// frames; config and protect inputs are stable core-domain levels
`timescale 1ns/1ns
module fpp_page_program
  import fpp_pkg::*;
#(
  parameter int MAIN_BYTES = 4096,
  parameter int SECTOR_BYTES = 1024,
  parameter int OTP_BYTES = 1024,
  parameter int SEC_W = $clog2(MAIN_BYTES / SECTOR_BYTES)
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic [3:0] spi_io_in,
  input wire logic [7:0] config_reg_two_volatile,
  input wire logic [7:0] config_reg_three_volatile,
  input wire logic array_protect,
  input wire logic erase_req,
  input wire logic [SEC_W-1:0] erase_sector,
  input wire logic clear_status_req,
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] status_reg_one_volatile,
  output logic [7:0] correction_status_reg,
  output logic correction_status_valid
);
  import fpp_pkg::*;

  localparam int TOT_UNITS = (MAIN_BYTES + OTP_BYTES) / UNIT_BYTES;
  localparam int MAIN_UNITS = MAIN_BYTES / UNIT_BYTES;
  localparam int SEC_UNITS = SECTOR_BYTES / UNIT_BYTES;
  localparam int UW = $clog2(TOT_UNITS);
  localparam logic [31:0] ADDR_LIMIT = 32'(MAIN_BYTES + OTP_BYTES);
  localparam logic [UW-1:0] LAST_UNIT = UW'(TOT_UNITS - 1);
  localparam logic [UW-1:0] SEC_LAST = UW'(SEC_UNITS - 1);

  // =========================================================
  // link domain: one nibble and a toggle per rising spi_sck
  // async reset since spi_sck may not run while resetn is low
  logic [3:0] lnk_nib_reg;
  logic lnk_tgl_reg;

  always_ff @(posedge spi_sck or negedge resetn) begin
    if (!resetn) begin
      lnk_nib_reg <= 4'h0;
      lnk_tgl_reg <= 1'b0;
    end else if (!spi_cs_n) begin
      lnk_nib_reg <= spi_io_in;
      lnk_tgl_reg <= ~lnk_tgl_reg;
    end
  end

  // =========================================================
  // crossing: cs path is one stage longer so the last nibble of a
  // frame is always taken before the frame end is seen
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  logic [3:0] nib_s1_reg, nib_s2_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg, cs_s4_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      {tgl_s1_reg, tgl_s2_reg, tgl_s3_reg} <= 3'h0;
      nib_s1_reg <= 4'h0;
      nib_s2_reg <= 4'h0;
      {cs_s1_reg, cs_s2_reg, cs_s3_reg, cs_s4_reg} <= 4'hf;
    end else if (clk_en) begin
      tgl_s1_reg <= lnk_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      nib_s1_reg <= lnk_nib_reg;
      nib_s2_reg <= nib_s1_reg;
      cs_s1_reg <= spi_cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      cs_s4_reg <= cs_s3_reg;
    end
  end

  // =========================================================
  // byte assembly and frame decode
  fpp_frame_t frame_reg;
  fpp_eng_t eng_reg;
  logic [7:0] shift_reg, opc_reg;
  logic [3:0] bit_cnt_reg;
  logic [31:0] addr_reg, page_base_reg;
  logic [2:0] addr_left_reg;
  logic [1:0] frame_bytes_reg;
  logic [8:0] ptr_reg;
  logic got_data_reg, load_start_reg, correction_status_read_cmd_go_reg;
  logic wip_reg, wel_reg, perr_reg;

  logic nib_evt, cs_rise, quad, byte_done, is_prog, data_wr;
  logic [3:0] step, bit_sum;
  logic [7:0] new_byte;
  logic [8:0] page_mask;
  logic [31:0] addr_full;

  assign nib_evt = tgl_s2_reg ^ tgl_s3_reg;
  assign cs_rise = cs_s3_reg & ~cs_s4_reg;
  assign quad = config_reg_two_volatile[CR2_QUAD_BIT];
  assign step = quad ? STEP_QUAD : STEP_SERIAL;
  assign bit_sum = bit_cnt_reg + step;
  assign byte_done = nib_evt && (bit_sum == BITS_PER_BYTE);
  assign new_byte = quad ? {shift_reg[3:0], nib_s2_reg}
                         : {shift_reg[6:0], nib_s2_reg[0]};
  assign page_mask = config_reg_three_volatile[CR3_PAGE512_BIT] ?
                     PAGE_MASK_LARGE : PAGE_MASK_SMALL;
  assign addr_full = {addr_reg[23:0], new_byte};
  assign is_prog = (opc_reg == OPC_PAGE_PROG) ||
                   (opc_reg == OPC_PAGE_PROG_WIDE);
  assign data_wr = byte_done && (frame_reg == FR_DATA);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      frame_reg <= FR_OPCODE;
      shift_reg <= 8'h00;
      opc_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      addr_reg <= 32'h0000_0000;
      page_base_reg <= 32'h0000_0000;
      addr_left_reg <= 3'h0;
      frame_bytes_reg <= 2'h0;
      ptr_reg <= 9'h000;
      got_data_reg <= 1'b0;
      load_start_reg <= 1'b0;
      correction_status_read_cmd_go_reg <= 1'b0;
    end else if (clk_en) begin
      load_start_reg <= 1'b0;
      correction_status_read_cmd_go_reg <= 1'b0;
      if (nib_evt) begin
        shift_reg <= new_byte;
        bit_cnt_reg <= byte_done ? 4'h0 : bit_sum;
      end
      if (byte_done) begin
        if (frame_bytes_reg != 2'h3) begin
          frame_bytes_reg <= frame_bytes_reg + 2'h1;
        end
        unique case (frame_reg)
          FR_OPCODE: begin
            opc_reg <= new_byte;
            addr_reg <= 32'h0000_0000;
            addr_left_reg <= (new_byte == OPC_PAGE_PROG_WIDE ||
                              new_byte == OPC_ECC_STAT_WIDE ||
                              config_reg_two_volatile[CR2_ADDR4_BIT]) ?
                             ADDR_LEN_LONG : ADDR_LEN_SHORT;
            if ((new_byte == OPC_PAGE_PROG ||
                 new_byte == OPC_PAGE_PROG_WIDE) &&
                wel_reg && !wip_reg) begin
              frame_reg <= FR_ADDR;
            end else if (new_byte == OPC_ECC_STAT ||
                         new_byte == OPC_ECC_STAT_WIDE) begin
              frame_reg <= FR_ADDR;
            end else begin
              frame_reg <= FR_IGNORE;
            end
          end
          FR_ADDR: begin
            addr_reg <= addr_full;
            addr_left_reg <= addr_left_reg - 3'h1;
            if (addr_left_reg == 3'h1) begin
              if (is_prog) begin
                frame_reg <= FR_DATA;
                ptr_reg <= addr_full[8:0] & page_mask;
                page_base_reg <= addr_full & ~{23'h0, page_mask};
                load_start_reg <= 1'b1;
              end else begin
                correction_status_read_cmd_go_reg <= 1'b1;
                frame_reg <= FR_IGNORE;
              end
            end
          end
          FR_DATA: begin
            ptr_reg <= (ptr_reg + 9'h001) & page_mask;
            got_data_reg <= 1'b1;
          end
          FR_IGNORE: begin
          end
        endcase
      end
      if (cs_rise) begin
        frame_reg <= FR_OPCODE;
        bit_cnt_reg <= 4'h0;
        frame_bytes_reg <= 2'h0;
        got_data_reg <= 1'b0;
      end
    end
  end

  logic prog_go, write_enable_cmd_ok;
  // a partial trailing byte or a frame with no data starts nothing
  assign prog_go = cs_rise && (frame_reg == FR_DATA) && got_data_reg &&
                   (bit_cnt_reg == 4'h0);
  assign write_enable_cmd_ok = cs_rise && (frame_reg == FR_IGNORE) &&
                   (opc_reg == OPC_WRITE_EN) &&
                   (frame_bytes_reg == 2'h1) && (bit_cnt_reg == 4'h0);

  AST_PTR_WRAP: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && data_wr && (ptr_reg == page_mask) |=> ptr_reg == 9'h000)
    else $error("load pointer did not wrap to byte zero");

  // =========================================================
  // page buffer: later bytes overwrite earlier ones at the same slot
  logic [127:0] pbuf_mem [PAGE_UNITS_MAX];
  logic [15:0] pmask_mem [PAGE_UNITS_MAX];

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < PAGE_UNITS_MAX; i++) begin
        pmask_mem[i] <= 16'h0000;
      end
    end else if (clk_en) begin
      if (load_start_reg) begin
        for (int i = 0; i < PAGE_UNITS_MAX; i++) begin
          pmask_mem[i] <= 16'h0000;
        end
      end else if (data_wr) begin
        pbuf_mem[ptr_reg[8:4]][{ptr_reg[3:0], 3'h0} +: 8] <= new_byte;
        pmask_mem[ptr_reg[8:4]][ptr_reg[3:0]] <= 1'b1;
      end
    end
  end

  // =========================================================
  // unit store: data, check bits, disable flag, programmed flag
  logic [127:0] data_mem [TOT_UNITS];
  logic [ECC_BITS-1:0] ecc_mem [TOT_UNITS];
  logic dis_mem [TOT_UNITS];
  logic used_mem [TOT_UNITS];

  logic [UW-1:0] eu_reg, eu_last_reg, pu;
  logic [4:0] pcnt_reg, plast_reg;
  logic prog_wr, erase_wr, prog_bad;
  logic [127:0] old_data, wmask, merged;
  logic [7:0] new_ecc;

  assign pu = UW'(page_base_reg[31:4]) + UW'(pcnt_reg);
  assign prog_wr = (eng_reg == EN_PROG) && (pmask_mem[pcnt_reg] != 16'h0);
  assign erase_wr = (eng_reg == EN_INIT) || (eng_reg == EN_ERASE);
  assign old_data = data_mem[pu];
  always_comb begin
    for (int b = 0; b < UNIT_BYTES; b++) begin
      wmask[b*8 +: 8] = {8{pmask_mem[pcnt_reg][b]}};
    end
  end
  // untouched bytes keep ones in the merge word so they stay as stored
  assign merged = old_data & (pbuf_mem[pcnt_reg] | ~wmask);
  assign new_ecc = fpp_ecc_calc(merged);
  assign prog_bad = array_protect || (page_base_reg >= ADDR_LIMIT);

  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (erase_wr) begin
        data_mem[eu_reg] <= {UNIT_BITS{1'b1}};
        ecc_mem[eu_reg] <= ERASED_ECC;
        dis_mem[eu_reg] <= 1'b0;
        used_mem[eu_reg] <= 1'b0;
      end else if (prog_wr) begin
        data_mem[pu] <= merged;
        if (used_mem[pu]) begin
          dis_mem[pu] <= 1'b1;
        end else begin
          ecc_mem[pu] <= new_ecc;
          used_mem[pu] <= 1'b1;
        end
      end
    end
  end

  AST_NO_BIT_SET: assert property (@(posedge core_clk) disable iff (!resetn)
    prog_wr |-> (merged & ~old_data) == 128'h0)
    else $error("programming would raise a bit");
  AST_FIRST_PROG_ECC: assert property (@(posedge core_clk)
    disable iff (!resetn)
    clk_en && prog_wr && !used_mem[pu] |=>
      ecc_mem[$past(pu)] == $past(new_ecc) && !dis_mem[$past(pu)])
    else $error("first program did not store check bits");
  AST_SECOND_PROG_DIS: assert property (@(posedge core_clk)
    disable iff (!resetn)
    clk_en && prog_wr && used_mem[pu] |=> dis_mem[$past(pu)])
    else $error("repeat program left correction enabled");
  AST_ERASE_ENABLES: assert property (@(posedge core_clk)
    disable iff (!resetn)
    clk_en && erase_wr |=> !dis_mem[$past(eu_reg)] &&
      ecc_mem[$past(eu_reg)] == ERASED_ECC)
    else $error("erase left a unit disabled");

  // =========================================================
  // engine: init wipe, page program walk, sector erase walk
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      eng_reg <= EN_INIT;
      eu_reg <= '0;
      eu_last_reg <= LAST_UNIT;
      pcnt_reg <= 5'h00;
      plast_reg <= PAGE_LAST_SMALL;
      wip_reg <= 1'b1;
    end else if (clk_en) begin
      unique case (eng_reg)
        EN_INIT, EN_ERASE: begin
          eu_reg <= eu_reg + UW'(1);
          if (eu_reg == eu_last_reg) begin
            eng_reg <= EN_IDLE;
            wip_reg <= 1'b0;
          end
        end
        EN_PROG: begin
          pcnt_reg <= pcnt_reg + 5'h01;
          if (pcnt_reg == plast_reg) begin
            eng_reg <= EN_IDLE;
            wip_reg <= 1'b0;
          end
        end
        EN_IDLE: begin
          if (prog_go && !prog_bad) begin
            eng_reg <= EN_PROG;
            wip_reg <= 1'b1;
            pcnt_reg <= 5'h00;
            plast_reg <= config_reg_three_volatile[CR3_PAGE512_BIT] ?
                         PAGE_LAST_LARGE : PAGE_LAST_SMALL;
          end else if (erase_req) begin
            // only main sectors are reachable: otp units erase only in the init wipe
            eng_reg <= EN_ERASE;
            wip_reg <= 1'b1;
            eu_reg <= UW'(erase_sector) * UW'(SEC_UNITS);
            eu_last_reg <= UW'(erase_sector) * UW'(SEC_UNITS) + SEC_LAST;
          end
        end
      endcase
    end
  end

  logic prog_done, prog_fail;
  assign prog_done = (eng_reg == EN_PROG) && (pcnt_reg == plast_reg);
  assign prog_fail = (eng_reg == EN_IDLE) && prog_go && prog_bad;

  // =========================================================
  // status bits; an error set beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wel_reg <= 1'b0;
      perr_reg <= 1'b0;
    end else if (clk_en) begin
      if (write_enable_cmd_ok) begin
        wel_reg <= 1'b1;
      end else if (prog_done || prog_fail) begin
        wel_reg <= 1'b0;
      end
      perr_reg <= prog_fail | (perr_reg & ~clear_status_req);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_reg_one_volatile <= 8'h00;
    end else if (clk_en) begin
      status_reg_one_volatile <= 8'h00;
      status_reg_one_volatile[SR1_WIP_BIT] <= wip_reg;
      status_reg_one_volatile[SR1_WEL_BIT] <= wel_reg;
      status_reg_one_volatile[SR1_PERR_BIT] <= perr_reg;
    end
  end

  AST_PROG_NEEDS_WEL: assert property (@(posedge core_clk)
    disable iff (!resetn)
    clk_en && $rose(eng_reg == EN_PROG) |-> $past(wel_reg))
    else $error("program started without write enable");
  AST_WIP_DURING_PROG: assert property (@(posedge core_clk)
    disable iff (!resetn)
    clk_en && eng_reg == EN_PROG |=> status_reg_one_volatile[SR1_WIP_BIT])
    else $error("busy flag low while programming");
  AST_END_CLEARS: assert property (@(posedge core_clk) disable iff (!resetn)
    clk_en && prog_done |=> !wip_reg && !wel_reg
      ##1 !status_reg_one_volatile[SR1_WIP_BIT])
    else $error("busy or latch not cleared at program end");
  AST_PERR_ON_FAIL: assert property (@(posedge core_clk)
    disable iff (!resetn)
    clk_en && prog_fail |=> perr_reg && eng_reg == EN_IDLE)
    else $error("failed program did not raise error");

  // =========================================================
  // corrected read port and ecc status command
  logic [UW-1:0] ru, su;
  logic [7:0] rsyn, ssyn;
  logic [127:0] rfix;
  logic [7:0] raw_byte, fix_byte;

  assign ru = UW'(rd_addr[31:4]);
  assign rsyn = ecc_mem[ru] ^ fpp_ecc_calc(data_mem[ru]);
  assign rfix = fpp_ecc_fix(data_mem[ru], rsyn);
  assign raw_byte = data_mem[ru][{rd_addr[3:0], 3'h0} +: 8];
  assign fix_byte = rfix[{rd_addr[3:0], 3'h0} +: 8];
  assign su = UW'(addr_reg[31:4]);
  assign ssyn = ecc_mem[su] ^ fpp_ecc_calc(data_mem[su]);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= rd_req;
      if (rd_req) begin
        if (rd_addr >= ADDR_LIMIT) begin
          rd_data <= 8'hff;
        end else if (dis_mem[ru]) begin
          rd_data <= raw_byte;
        end else begin
          rd_data <= fix_byte;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      correction_status_reg <= 8'h00;
      correction_status_valid <= 1'b0;
    end else if (clk_en) begin
      correction_status_valid <= correction_status_read_cmd_go_reg;
      if (correction_status_read_cmd_go_reg) begin
        correction_status_reg <= 8'h00;
        if (addr_reg < ADDR_LIMIT) begin
          if (dis_mem[su]) begin
            correction_status_reg[ECCST_DISABLED_BIT] <= 1'b1;
          end else if (fpp_is_pow2(ssyn)) begin
            correction_status_reg[ECCST_CHECK_ERR_BIT] <= 1'b1;
          end else if (ssyn != 8'h00 && ssyn <= ECC_MAX_POS) begin
            correction_status_reg[ECCST_DATA_FIX_BIT] <= 1'b1;
          end else if (ssyn != 8'h00) begin
            correction_status_reg[ECCST_UNCORR_BIT] <= 1'b1;
          end
        end
      end
    end
  end

  AST_RAW_WHEN_DIS: assert property (@(posedge core_clk)
    disable iff (!resetn)
    clk_en && rd_req && rd_addr < ADDR_LIMIT && dis_mem[ru] |=>
      rd_valid && rd_data == $past(raw_byte))
    else $error("disabled unit read was altered");
  AST_FIX_WHEN_EN: assert property (@(posedge core_clk)
    disable iff (!resetn)
    clk_en && rd_req && rd_addr < ADDR_LIMIT && !dis_mem[ru] |=>
      rd_valid && rd_data == $past(fix_byte))
    else $error("enabled unit read not corrected");

endmodule : fpp_page_program

// >>> logic/fpp_pkg.sv
// constants, types and ecc helpers for the page program block
// assumes a 16-byte unit with a 128-bit data word and 8 check bits
package fpp_pkg;

  // =========================================================
  // command opcodes
  localparam logic [7:0] OPC_WRITE_EN = 8'h06;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_PAGE_PROG_WIDE = 8'h12;
  localparam logic [7:0] OPC_ECC_STAT = 8'h19;
  localparam logic [7:0] OPC_ECC_STAT_WIDE = 8'h18;

  // =========================================================
  // geometry
  localparam int UNIT_BYTES = 16;
  localparam int UNIT_BITS = 128;
  localparam int ECC_BITS = 8;
  localparam int PAGE_UNITS_MAX = 32;
  localparam logic [8:0] PAGE_MASK_SMALL = 9'h0ff;
  localparam logic [8:0] PAGE_MASK_LARGE = 9'h1ff;
  localparam logic [4:0] PAGE_LAST_SMALL = 5'h0f;
  localparam logic [4:0] PAGE_LAST_LARGE = 5'h1f;
  localparam logic [2:0] ADDR_LEN_SHORT = 3'h3;
  localparam logic [2:0] ADDR_LEN_LONG = 3'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] STEP_SERIAL = 4'h1;
  localparam logic [3:0] STEP_QUAD = 4'h4;

  // =========================================================
  // configuration and status bit positions
  localparam int CR2_ADDR4_BIT = 7;
  localparam int CR2_QUAD_BIT = 6;
  localparam int CR3_PAGE512_BIT = 4;
  localparam int SR1_WIP_BIT = 0;
  localparam int SR1_WEL_BIT = 1;
  localparam int SR1_PERR_BIT = 6;
  localparam int ECCST_DISABLED_BIT = 0;
  localparam int ECCST_DATA_FIX_BIT = 1;
  localparam int ECCST_CHECK_ERR_BIT = 2;
  localparam int ECCST_UNCORR_BIT = 3;

  // =========================================================
  // hamming code: data bit i sits at the i-th non power of two
  localparam logic [7:0] ECC_FIRST_POS = 8'h03;
  localparam logic [7:0] ECC_MAX_POS = 8'h88;

  typedef enum logic [1:0] {FR_OPCODE, FR_ADDR, FR_DATA, FR_IGNORE}
    fpp_frame_t;
  typedef enum logic [1:0] {EN_INIT, EN_IDLE, EN_PROG, EN_ERASE}
    fpp_eng_t;

  function automatic logic fpp_is_pow2(input logic [7:0] v);
    return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction : fpp_is_pow2

  function automatic logic [7:0] fpp_next_pos(input logic [7:0] p);
    logic [7:0] n;
    n = p + 8'h01;
    if (fpp_is_pow2(n)) begin
      n = n + 8'h01;
    end
    return n;
  endfunction : fpp_next_pos

  function automatic logic [7:0] fpp_ecc_calc(input logic [127:0] d);
    logic [7:0] c;
    logic [7:0] p;
    c = 8'h00;
    p = ECC_FIRST_POS;
    for (int i = 0; i < UNIT_BITS; i++) begin
      if (d[i]) begin
        c = c ^ p;
      end
      p = fpp_next_pos(p);
    end
    return c;
  endfunction : fpp_ecc_calc

  function automatic logic [127:0] fpp_ecc_fix(input logic [127:0] d,
                                               input logic [7:0] syn);
    logic [127:0] r;
    logic [7:0] p;
    r = d;
    p = ECC_FIRST_POS;
    for (int i = 0; i < UNIT_BITS; i++) begin
      if (syn == p) begin
        r[i] = ~d[i];
      end
      p = fpp_next_pos(p);
    end
    return r;
  endfunction : fpp_ecc_fix

  localparam logic [7:0] ERASED_ECC = fpp_ecc_calc({UNIT_BITS{1'b1}});

endpackage : fpp_pkg

// >>> sim/fpp_host_model.sv
// spi host model that sends command frames to the page program block
// assumes the bench calls frame(); quad is set by the bench with cfg bit 6
`timescale 1ns/1ns
module fpp_host_model (
  output logic spi_sck,
  output logic spi_cs_n,
  output logic [3:0] spi_io_in
);
  logic quad;
  initial begin
    quad = 1'b0;
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_io_in = 4'hf;
  end
  // =========================================================
  // one whole frame; sck stands low between frames
  task automatic frame(input logic [7:0] b[$]);
    spi_cs_n = 1'b0;
    foreach (b[i]) begin
      for (int k = 7; k >= 0; k -= (quad ? 4 : 1)) begin
        spi_io_in = quad ? b[i][k-:4] : {3'h7, b[i][k]};
        #32 spi_sck = 1'b1;
        #32 spi_sck = 1'b0;
      end
    end
    // released lines float high, so a stale bit never looks valid
    #8 spi_cs_n = 1'b1;
    spi_io_in = 4'hf;
    #100;
  endtask : frame
endmodule : fpp_host_model

// >>> sim/testbench.sv
// self-checking bench for the page program block
// assumes fpp_host_model drives the link; small array sizes for speed
`timescale 1ns/1ns
module testbench;
  import fpp_pkg::*;
  logic core_clk = 1'b0, resetn, clk_en, prot, erase_req, esec, clr, rd_req;
  logic [7:0] cfg2, cfg3, rd_data, sr, csr;
  logic [31:0] rd_addr;
  logic sck, cs_n, rd_valid, csv;
  logic [3:0] io;
  int mismatches = 0, cmp_count = 0;
  logic [15:0] rows [8] = '{16'h1005, 16'h113c, 16'h12ff, 16'hff11,
                            16'h0022, 16'h01ff, 16'h4077, 16'h20ff};
  always #2 core_clk = ~core_clk;
  fpp_host_model u_fpp_host_model (.spi_sck(sck), .spi_cs_n(cs_n),
    .spi_io_in(io));
  fpp_page_program #(.MAIN_BYTES(512), .SECTOR_BYTES(256),
    .OTP_BYTES(256)) u_fpp_page_program (.core_clk(core_clk),
    .resetn(resetn), .clk_en(clk_en), .spi_sck(sck), .spi_cs_n(cs_n),
    .spi_io_in(io), .config_reg_two_volatile(cfg2),
    .config_reg_three_volatile(cfg3), .array_protect(prot),
    .erase_req(erase_req), .erase_sector(esec), .clear_status_req(clr),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .status_reg_one_volatile(sr),
    .correction_status_reg(csr), .correction_status_valid(csv));
  // =========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic idle();
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if (sr[0] === 1'b0) return;
    end
    mismatches++;
  endtask : idle
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    rd_req = 1'b1;
    rd_addr = {16'h0, a};
    @(negedge core_clk);
    rd_req = 1'b0;
    chk({7'h0, rd_valid}, 8'h01);
    chk(rd_data, exp);
  endtask : rd
  task automatic wprog(input logic [7:0] b[$]);
    u_fpp_host_model.frame('{OPC_WRITE_EN});
    u_fpp_host_model.frame(b);
    idle();
  endtask : wprog
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    #200000 mismatches++;
    conclude();
  end
  // =========================================================
  // scenarios
  initial begin
    {resetn, prot, erase_req, esec, clr, rd_req} = '0;
    {cfg2, cfg3, rd_addr} = '0;
    clk_en = 1'b1;
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    idle();
    u_fpp_host_model.frame('{8'h02, 8'h00, 8'h00, 8'h20, 8'h00});
    wprog('{8'h02, 8'h00, 8'h00, 8'h10, 8'ha5, 8'h3c});
    chk(sr, 8'h00);
    wprog('{8'h02, 8'h00, 8'h00, 8'h10, 8'h0f});
    wprog('{8'h02, 8'h00, 8'h00, 8'hff, 8'h11, 8'h22});
    cfg2 = 8'hc0;
    u_fpp_host_model.quad = 1'b1;
    wprog('{8'h12, 8'h00, 8'h00, 8'h00, 8'h40, 8'h77});
    cfg2 = 8'h00;
    u_fpp_host_model.quad = 1'b0;
    u_fpp_host_model.frame('{OPC_ECC_STAT, 8'h00, 8'h00, 8'h10});
    chk(csr & 8'h01, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rd(rows[i][15:8], rows[i][7:0]);
    end
    @(negedge core_clk);
    erase_req = 1'b1;
    @(negedge core_clk);
    erase_req = 1'b0;
    idle();
    rd(8'h10, 8'hff);
    u_fpp_host_model.frame('{OPC_ECC_STAT, 8'h00, 8'h00, 8'h10});
    chk(csr & 8'h01, 8'h00);
    prot = 1'b1;
    wprog('{8'h02, 8'h00, 8'h00, 8'h30, 8'h00});
    chk(sr, 8'h40);
    rd(8'h30, 8'hff);
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(sr, 8'h00);
    prot = 1'b0;
    // a 512-byte page wraps from 1ffh back to 000h, not to 100h
    cfg3 = 8'h10;
    wprog('{8'h02, 8'h00, 8'h01, 8'hff, 8'h33, 8'h44});
    cfg3 = 8'h00;
    rd(16'h01ff, 8'h33);
    rd(16'h0000, 8'h44);
    // otp unit programmed twice: correction disabled for good
    wprog('{8'h02, 8'h00, 8'h02, 8'h00, 8'hf0});
    wprog('{8'h02, 8'h00, 8'h02, 8'h00, 8'h0f});
    rd(16'h0200, 8'h00);
    u_fpp_host_model.frame('{OPC_ECC_STAT, 8'h00, 8'h02, 8'h00});
    chk(csr & 8'h01, 8'h01);
    // a frozen core must not answer a read
    @(negedge core_clk);
    clk_en = 1'b0;
    rd_req = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({7'h0, rd_valid}, 8'h00);
    rd_req = 1'b0;
    clk_en = 1'b1;
    conclude();
  end
endmodule : testbench
